// file: hw/mcr_defines.svh
// Offsets, field positions, reset values and timing figures of the monitor
`ifndef MCR_DEFINES_SVH
`define MCR_DEFINES_SVH
`define MCR_ADDR_CFG        8'h00
`define MCR_ADDR_RES_FIRST  8'h01
`define MCR_ADDR_RES_LAST   8'h06
`define MCR_CFG_RESET       16'h7127
`define MCR_RESULT_RESET    16'h0000
`define MCR_RST_BIT         15
`define MCR_EN_HI           14
`define MCR_AVG_HI          11
`define MCR_AVG_LO          9
`define MCR_BCT_HI          8
`define MCR_BCT_LO          6
`define MCR_SCT_HI          5
`define MCR_SCT_LO          3
`define MCR_MODE_CONT       2
`define MCR_MODE_BUS        1
`define MCR_MODE_SHUNT      0
`define MCR_STEP_LAST       3'h5
`define MCR_SAMPLE_W        13
`define MCR_ACC_W           24
`define MCR_TIMER_W         17
`define MCR_CLK_PERIOD_NS   100
`define MCR_CT0_NS          140000
`define MCR_CT1_NS          204000
`define MCR_CT2_NS          332000
`define MCR_CT3_NS          588000
`define MCR_CT4_NS          1100000
`define MCR_CT5_NS          2116000
`define MCR_CT6_NS          4156000
`define MCR_CT7_NS          8244000
`define MCR_AVG_SH0         4'h0
`define MCR_AVG_SH1         4'h2
`define MCR_AVG_SH2         4'h4
`define MCR_AVG_SH3         4'h6
`define MCR_AVG_SH4         4'h7
`define MCR_AVG_SH5         4'h8
`define MCR_AVG_SH6         4'h9
`define MCR_AVG_SH7         4'ha
`endif

// file: hw/mcr_pkg.sv
// Types of the monitor configuration and result block
package mcr_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_CONV = 2'b11,
        ST_HALT = 2'b10
    } mcr_state_e;
endpackage

// file: hw/mcr_monitor.sv
// Configuration register, conversion sequencer and result registers
`include "mcr_defines.svh"

// How it works
// - Bus conversion time field bits 8:6 picks eight times, reset 1.1 ms.
// - Shunt conversion time field bits 5:3 uses the same times, reset 1.1 ms.
// - Mode bits 2:0: 0,4 power-down; 1-3 triggered; 5-7 continuous.
// - Mode resets to 7, continuous shunt and bus.
// - Each of three channels can be enabled on its own.
// - Reading the configuration never changes settings or conversions.
// - A configuration write halts conversion, then restarts with new settings.
// - Shunt result holds the averaged shunt drop, 40 uV step.
// - Results are two's complement, sign at 15, code 14:3, bits 2:0 zero.
// - Bus result holds rail level, 8 mV step, same layout.
// - Shunt results at read-only 01h, 03h, 05h, reset zero.
// - Bus results of channels 1 and 2 at 02h and 04h, reset zero.
// - Channel 3 bus result at 06h, same format.
// - Averaging field picks 1 to 1024 samples, reset 1.
// - Writing bit 15 resets every register; the bit self-clears.
// - Enable bit 0 disables a channel; all enabled after reset.
module mcr_monitor #(
    parameter int unsigned CONV_CYC_0 = `MCR_CT0_NS / `MCR_CLK_PERIOD_NS,
    parameter int unsigned CONV_CYC_1 = `MCR_CT1_NS / `MCR_CLK_PERIOD_NS,
    parameter int unsigned CONV_CYC_2 = `MCR_CT2_NS / `MCR_CLK_PERIOD_NS,
    parameter int unsigned CONV_CYC_3 = `MCR_CT3_NS / `MCR_CLK_PERIOD_NS,
    parameter int unsigned CONV_CYC_4 = `MCR_CT4_NS / `MCR_CLK_PERIOD_NS,
    parameter int unsigned CONV_CYC_5 = `MCR_CT5_NS / `MCR_CLK_PERIOD_NS,
    parameter int unsigned CONV_CYC_6 = `MCR_CT6_NS / `MCR_CLK_PERIOD_NS,
    parameter int unsigned CONV_CYC_7 = `MCR_CT7_NS / `MCR_CLK_PERIOD_NS
) (
    input  wire logic                       mclk_i,
    input  wire logic                       arst_n_i,
    input  wire logic [7:0]                 reg_addr_i,
    input  wire logic                       reg_wr_i,
    input  wire logic [15:0]                reg_wdata_i,
    input  wire logic                       reg_wr_busy_i,
    input  wire logic                       reg_rd_i,
    output logic      [15:0]                reg_rdata_o,
    input  wire logic [`MCR_SAMPLE_W-1:0]   adc_data_i,
    output logic      [1:0]                 adc_chan_o,
    output logic                            adc_bus_sel_o,
    output logic                            adc_active_o
);
    localparam int unsigned TW = `MCR_TIMER_W;
    localparam int unsigned SW = `MCR_SAMPLE_W;
    localparam int unsigned AW = `MCR_ACC_W;

    if (CONV_CYC_0 < 1 || CONV_CYC_1 < 1 || CONV_CYC_2 < 1 || CONV_CYC_3 < 1 ||
        CONV_CYC_4 < 1 || CONV_CYC_5 < 1 || CONV_CYC_6 < 1 || CONV_CYC_7 < 1 ||
        CONV_CYC_7 >= (1 << TW)) begin : g_bad_cyc
        $error("Conversion cycle counts out of range");
    end

    // Cycle count for a conversion time code
    function automatic logic [TW-1:0] conv_cycles(input logic [2:0] code);
        case (code)
            3'h0: conv_cycles = TW'(CONV_CYC_0);
            3'h1: conv_cycles = TW'(CONV_CYC_1);
            3'h2: conv_cycles = TW'(CONV_CYC_2);
            3'h3: conv_cycles = TW'(CONV_CYC_3);
            3'h4: conv_cycles = TW'(CONV_CYC_4);
            3'h5: conv_cycles = TW'(CONV_CYC_5);
            3'h6: conv_cycles = TW'(CONV_CYC_6);
            default: conv_cycles = TW'(CONV_CYC_7);
        endcase
    endfunction

    // Averaging divide shift for a sample count code
    function automatic logic [3:0] avg_shift(input logic [2:0] code);
        case (code)
            3'h0: avg_shift = `MCR_AVG_SH0;
            3'h1: avg_shift = `MCR_AVG_SH1;
            3'h2: avg_shift = `MCR_AVG_SH2;
            3'h3: avg_shift = `MCR_AVG_SH3;
            3'h4: avg_shift = `MCR_AVG_SH4;
            3'h5: avg_shift = `MCR_AVG_SH5;
            3'h6: avg_shift = `MCR_AVG_SH6;
            default: avg_shift = `MCR_AVG_SH7;
        endcase
    endfunction

    mcr_pkg::mcr_state_e state_q, state_d;
    logic [15:0]        cfg_q, cfg_d;
    logic [15:0]        res_q [6];
    logic [2:0]         step_q, step_d;
    logic [TW-1:0]      timer_q, timer_d;
    logic [10:0]        nsamp_q, nsamp_d;
    logic signed [AW-1:0] acc_q, acc_d;
    logic [SW-1:0]      adc_s1_q, adc_s2_q;
    logic [15:0]        rdata_q;

    // Register access decode
    wire cfg_wr   = reg_wr_i && (reg_addr_i == `MCR_ADDR_CFG);
    wire soft_rst = cfg_wr && reg_wdata_i[`MCR_RST_BIT];
    wire [15:0] new_cfg = soft_rst ? `MCR_CFG_RESET : {1'b0, reg_wdata_i[14:0]};
    wire new_pdown = (new_cfg[`MCR_MODE_BUS:`MCR_MODE_SHUNT] == 2'b00);
    wire res_hit = (reg_addr_i >= `MCR_ADDR_RES_FIRST) && (reg_addr_i <= `MCR_ADDR_RES_LAST);
    wire [2:0] res_idx = 3'(reg_addr_i - `MCR_ADDR_RES_FIRST);
    wire [15:0] rd_sel = (reg_addr_i == `MCR_ADDR_CFG) ? cfg_q :
                         res_hit ? res_q[res_idx] : 16'h0000;

    // Step decode: step = channel * 2 + bus select
    wire [1:0] step_ch  = step_q[2:1];
    wire       step_bus = step_q[0];
    wire       ch_on    = cfg_q[`MCR_EN_HI - step_ch];
    wire       sig_on   = step_bus ? cfg_q[`MCR_MODE_BUS] : cfg_q[`MCR_MODE_SHUNT];
    wire       step_ok  = ch_on && sig_on;
    wire [2:0] ct_code  = step_bus ? cfg_q[`MCR_BCT_HI:`MCR_BCT_LO]
                                   : cfg_q[`MCR_SCT_HI:`MCR_SCT_LO];
    wire [TW-1:0] conv_len = conv_cycles(ct_code) - TW'(1);
    wire [3:0] avg_sh   = avg_shift(cfg_q[`MCR_AVG_HI:`MCR_AVG_LO]);
    wire [10:0] samp_last = 11'((1 << avg_sh) - 1);
    wire       last_step = (step_q == `MCR_STEP_LAST);
    wire       sample_now = (state_q == mcr_pkg::ST_CONV) && (timer_q == '0);
    wire       result_now = sample_now && (nsamp_q == samp_last);
    wire signed [AW-1:0] acc_sum = acc_q + AW'($signed(adc_s2_q));
    wire signed [AW-1:0] acc_avg = acc_sum >>> avg_sh;
    wire [15:0] result_word = {acc_avg[SW-1:0], 3'b000};

    always_comb begin
        state_d = state_q;
        cfg_d   = cfg_q;
        step_d  = step_q;
        timer_d = timer_q;
        nsamp_d = nsamp_q;
        acc_d   = acc_q;
        if (cfg_wr) begin
            cfg_d   = new_cfg;
            step_d  = 3'h0;
            nsamp_d = '0;
            acc_d   = '0;
            state_d = new_pdown ? mcr_pkg::ST_IDLE : mcr_pkg::ST_LOAD;
        end else if (reg_wr_busy_i) begin
            state_d = mcr_pkg::ST_HALT;
            step_d  = 3'h0;
            nsamp_d = '0;
            acc_d   = '0;
        end else begin
            case (state_q)
                mcr_pkg::ST_IDLE: begin
                    state_d = mcr_pkg::ST_IDLE;
                end
                mcr_pkg::ST_HALT: begin
                    state_d = mcr_pkg::ST_LOAD;
                end
                mcr_pkg::ST_LOAD: begin
                    if (step_ok) begin
                        timer_d = conv_len;
                        state_d = mcr_pkg::ST_CONV;
                    end else if (last_step) begin
                        step_d  = 3'h0;
                        state_d = cfg_q[`MCR_MODE_CONT] ? mcr_pkg::ST_LOAD
                                                         : mcr_pkg::ST_IDLE;
                    end else begin
                        step_d = step_q + 3'h1;
                    end
                end
                default: begin
                    if (!sample_now) begin
                        timer_d = timer_q - TW'(1);
                    end else if (!result_now) begin
                        acc_d   = acc_sum;
                        nsamp_d = nsamp_q + 11'h1;
                        timer_d = conv_len;
                    end else begin
                        acc_d   = '0;
                        nsamp_d = '0;
                        step_d  = last_step ? 3'h0 : step_q + 3'h1;
                        state_d = (last_step && !cfg_q[`MCR_MODE_CONT]) ?
                                  mcr_pkg::ST_IDLE : mcr_pkg::ST_LOAD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            adc_s1_q <= '0;
            adc_s2_q <= '0;
            rdata_q  <= 16'h0000;
        end else begin
            adc_s1_q <= adc_data_i;
            adc_s2_q <= adc_s1_q;
            if (reg_rd_i) begin
                rdata_q <= rd_sel;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= mcr_pkg::ST_LOAD;
            cfg_q   <= `MCR_CFG_RESET;
            step_q  <= 3'h0;
            timer_q <= '0;
            nsamp_q <= '0;
            acc_q   <= '0;
        end else begin
            state_q <= state_d;
            cfg_q   <= cfg_d;
            step_q  <= step_d;
            timer_q <= timer_d;
            nsamp_q <= nsamp_d;
            acc_q   <= acc_d;
        end
    end

    for (genvar i = 0; i < 6; i++) begin : g_res
        always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                res_q[i] <= `MCR_RESULT_RESET;
            end else if (soft_rst) begin
                res_q[i] <= `MCR_RESULT_RESET;
            end else if (result_now && !cfg_wr && !reg_wr_busy_i && step_q == 3'(i)) begin
                res_q[i] <= result_word;
            end
        end
    end

    assign reg_rdata_o   = rdata_q;
    assign adc_chan_o    = step_ch;
    assign adc_bus_sel_o = step_bus;
    assign adc_active_o  = (state_q == mcr_pkg::ST_CONV);

endmodule // mcr_monitor

// file: dv/mcr_checker.sv
// Port assertions for the monitor
module mcr_checker (
    input wire logic        mclk_i,
    input wire logic        arst_n_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_wr_busy_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [1:0]  adc_chan_o,
    input wire logic        adc_bus_sel_o,
    input wire logic        adc_active_o
);
    logic [15:0] cfg_q;
    wire         cfg_wr = reg_wr_i && reg_addr_i == 8'h00;
    wire         pd_wr = cfg_wr && !reg_wdata_i[15] && reg_wdata_i[1:0] == 2'h0;
    wire         rd_go = reg_rd_i && !reg_wr_i;
    always_ff @(posedge mclk_i or negedge arst_n_i)
        if (!arst_n_i) cfg_q <= 16'h7127;
        else if (cfg_wr) cfg_q <= reg_wdata_i[15] ? 16'h7127 : reg_wdata_i;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_off2; !adc_active_o ##1 !adc_active_o; endsequence
    a_busy_halts: assert property (reg_wr_busy_i |=> !adc_active_o) else $error("busy");
    a_power_down: assert property (pd_wr |=> s_off2) else $error("power-down");
    a_sel_by_mode: assert property (adc_active_o |->
        (adc_bus_sel_o ? cfg_q[1] : cfg_q[0])) else $error("signal off");
    a_chan_on: assert property (adc_active_o |->
        adc_chan_o != 2'h3 && cfg_q[14 - adc_chan_o]) else $error("channel off");
    a_res_low_zero: assert property (rd_go && reg_addr_i != 8'h00
        |=> reg_rdata_o[2:0] == 3'h0) else $error("low bits");
    a_unmapped_zero: assert property (rd_go && reg_addr_i > 8'h06
        |=> reg_rdata_o == 16'h0000) else $error("unmapped");
    a_cfg_readback: assert property (rd_go && reg_addr_i == 8'h00
        |=> reg_rdata_o == {1'b0, cfg_q[14:0]}) else $error("config");
    a_rdata_holds: assert property (!reg_rd_i && !reg_wr_i
        |=> $stable(reg_rdata_o)) else $error("rdata moved");
endmodule // mcr_checker
bind mcr_monitor mcr_checker u_chk (.mclk_i, .arst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
    .reg_wr_busy_i, .reg_rd_i, .reg_rdata_o, .adc_chan_o, .adc_bus_sel_o, .adc_active_o);

// file: dv/mcr_host.sv
// Register-port host model for the monitor
module mcr_host (
    input  wire logic        mclk_i,
    input  wire logic [15:0] rdata_i,
    output logic      [7:0]  addr_o,
    output logic             wr_o,
    output logic      [15:0] wdata_o,
    output logic             busy_o,
    output logic             rd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 16'h0000;
        busy_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        busy_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge mclk_i);
        wr_o <= 1'b0;
        busy_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge mclk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask
endmodule // mcr_host

// file: dv/tb_monitor_config_and_results.sv
// Testbench for the monitor
module tb_monitor_config_and_results;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        reg_wr_i, reg_wr_busy_i, reg_rd_i, adc_bus_sel_o, adc_active_o;
    logic [7:0]  reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, v;
    logic [12:0] adc_data_i = 13'h0000;
    logic [1:0]  adc_chan_o;
    int          fails = 0, cmp_count = 0;
    logic [12:0] smp [8] = '{13'h1830, 13'h0fff, 13'h0001, 13'h1fff, 13'h0400, 13'h1000, 0, 0};
    wire         last_on = adc_active_o && adc_chan_o == 2'h2 && adc_bus_sel_o;
    initial forever #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i) adc_data_i <= smp[{adc_chan_o, adc_bus_sel_o}];
    mcr_monitor #(.CONV_CYC_0(4), .CONV_CYC_1(5), .CONV_CYC_2(6), .CONV_CYC_3(7),
        .CONV_CYC_4(8), .CONV_CYC_5(9), .CONV_CYC_6(10), .CONV_CYC_7(11)) dut (.mclk_i,
        .arst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_wr_busy_i, .reg_rd_i,
        .reg_rdata_o, .adc_data_i, .adc_chan_o, .adc_bus_sel_o, .adc_active_o);
    mcr_host host (.mclk_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .wr_o(reg_wr_i),
        .wdata_o(reg_wdata_i), .busy_o(reg_wr_busy_i), .rd_o(reg_rd_i));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) fails++;
        if (seen !== exp) $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    endtask
    task automatic test_done;
        $display("checks=%0d fails=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        host.rd(a, v);
        chk(v, e);
    endtask
    task automatic wait_sig(input bit last, input logic lvl);
        int n;
        #1;
        for (n = 0; n < 400 && (last ? last_on : adc_active_o) !== lvl; n++) @(posedge mclk_i) #1;
        chk(16'(n / 400), 16'h0000);
        if (n == 400) test_done;
    endtask
    task automatic measure(input logic [15:0] cfg, input int cyc);
        int n;
        host.wr(8'h00, cfg);
        wait_sig(1'b0, 1'b1);
        for (n = 0; n < 200 && adc_active_o === 1'b1; n++) @(posedge mclk_i) #1;
        chk(16'(n), 16'(cyc));
    endtask
    task automatic t_reset;
        host.wr(8'h01, 16'h1234);
        for (int a = 0; a < 6; a++) rd_chk(a == 0 ? 8'h01 : 8'(7 - a), 16'h0000);
        rd_chk(8'h07, 16'h0000);
        rd_chk(8'h00, 16'h7127);
        wait_sig(1'b1, 1'b1);
        wait_sig(1'b0, 1'b0);
        for (int k = 0; k < 6; k++) rd_chk(8'(k + 1), {smp[k], 3'h0});
    endtask
    task automatic t_trig;
        host.wr(8'h00, 16'h8000);
        rd_chk(8'h06, 16'h0000);
        rd_chk(8'h00, 16'h7127);
        host.wr(8'h00, 16'h5203);
        wait_sig(1'b1, 1'b1);
        wait_sig(1'b0, 1'b0);
        for (int k = 0; k < 6; k++)
            rd_chk(8'(k + 1), k / 2 == 1 ? 16'h0000 : {smp[k], 3'h0});
        repeat (20) @(posedge mclk_i) #1;
        chk(16'(adc_active_o), 16'h0000);
    endtask
    task automatic t_times;
        for (int c = 0; c < 8; c++) begin
            measure(16'h4005 | 16'(c << 3), 4 + c);
            measure(16'h4006 | 16'(c << 6), 4 + c);
        end
        host.wr(8'h00, 16'h7000);
        rd_chk(8'h00, 16'h7000);
    endtask
    initial begin
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        t_reset;
        t_trig;
        t_times;
        test_done;
    end
endmodule // tb_monitor_config_and_results
